// *** rtl/dcr_pkg.sv ***
// Shared constants of the DMA channel control register block
package dcr_pkg;

  // Bus address width and register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_BASE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ALT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SOFT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_BLKSET = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_BLKCLR = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_CHAN_ON_SET_BITS = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_CHAN_ON_CLEAR_BITS = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_ALTSET = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_ALTCLR = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_HIGH_PRIO_SET_BITS = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_HIGH_PRIO_CLEAR_BITS = 8'h3C;
  localparam logic [ADDR_W-1:0] OFF_ERRFLAG = 8'h4C;
  localparam logic [ADDR_W-1:0] OFF_DONEFLAG = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_DONEIESET = 8'h54;
  localparam logic [ADDR_W-1:0] OFF_DONEIECLR = 8'h58;
  localparam logic [ADDR_W-1:0] OFF_ERRIESET = 8'h5C;
  localparam logic [ADDR_W-1:0] OFF_ERRIECLR = 8'h60;

  // Field positions
  localparam int ON_BIT = 0;
  localparam int ERR_BIT = 0;
  localparam int RO_BASE_BITS = 5;

  // Reset values
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/dcr_gate_if.sv ***
// Carrier between the register file and the request gate
`timescale 1ns/1ps
interface dcr_gate_if #(
  parameter int ChanCount = 32
);
  logic controllerOn;
  logic [ChanCount-1:0] chanOn;
  logic [ChanCount-1:0] reqBlock;
  logic [ChanCount-1:0] softPulse;
  logic [ChanCount-1:0] periphReq;
  logic [ChanCount-1:0] chanReq;

  modport regs (output controllerOn, chanOn, reqBlock, softPulse, periphReq,
    input chanReq);
  modport gate (input controllerOn, chanOn, reqBlock, softPulse, periphReq,
    output chanReq);
endinterface

// *** rtl/dcr_req_gate.sv ***
// Per-channel transfer request gate
`timescale 1ns/1ps
module dcr_req_gate #(
  parameter int ChanCount = 32
) (
  dcr_gate_if.gate gif
);

  // Request per channel, while controller and channel are on: soft pulse or unblocked peripheral level
  genvar ch;
  generate
    for (ch = 0; ch < ChanCount; ch++) begin : g_chan
      assign gif.chanReq[ch] = gif.controllerOn & gif.chanOn[ch] &
        (gif.softPulse[ch] | (gif.periphReq[ch] & ~gif.reqBlock[ch]));
    end
  endgenerate

endmodule // dcr_req_gate

// *** rtl/dma_channel_control_regs.sv ***
// DMA channel control registers with AXI4-Lite slave
`timescale 1ns/1ps

module dma_channel_control_regs #(
  parameter int ChanCount = 32
) (
  core_clk,
  reset,
  clkEn,
  awvalid,
  awready,
  awaddr,
  wvalid,
  wready,
  wdata,
  wstrb,
  bvalid,
  bready,
  bresp,
  arvalid,
  arready,
  araddr,
  rvalid,
  rready,
  rdata,
  rresp,
  periphReqIn,
  chanDoneIn,
  busErrorIn,
  controllerOn,
  chanEnable,
  altSelect,
  highPrio,
  chanRequest,
  ctrlBaseAddr,
  altBaseAddr,
  irq
);
  input wire logic core_clk;
  input wire logic reset;
  input wire logic clkEn;
  input wire logic awvalid;
  output logic awready;
  input wire logic [dcr_pkg::ADDR_W-1:0] awaddr;
  input wire logic wvalid;
  output logic wready;
  input wire logic [31:0] wdata;
  input wire logic [3:0] wstrb;
  output logic bvalid;
  input wire logic bready;
  output logic [1:0] bresp;
  input wire logic arvalid;
  output logic arready;
  input wire logic [dcr_pkg::ADDR_W-1:0] araddr;
  output logic rvalid;
  input wire logic rready;
  output logic [31:0] rdata;
  output logic [1:0] rresp;
  input wire logic [ChanCount-1:0] periphReqIn;
  input wire logic [ChanCount-1:0] chanDoneIn;
  input wire logic busErrorIn;
  output logic controllerOn;
  output logic [ChanCount-1:0] chanEnable;
  output logic [ChanCount-1:0] altSelect;
  output logic [ChanCount-1:0] highPrio;
  output logic [ChanCount-1:0] chanRequest;
  output logic [31:0] ctrlBaseAddr;
  output logic [31:0] altBaseAddr;
  output logic irq;

  // Table alignment: 5 bits for one channel up to 10 for 17 to 32
  localparam int RoBits = dcr_pkg::RO_BASE_BITS + $clog2(ChanCount);
  localparam logic [31:0] RoMask = (32'h1 << RoBits) - 32'h1;
  localparam logic [31:0] AltOffset = 32'h1 << (RoBits - 1);

  typedef struct packed {
    logic awReady;
    logic wReady;
    logic awHeld;
    logic wHeld;
    logic [dcr_pkg::ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [31:0] wMask;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic on;
    logic [31:0] base;
    logic [31:0] alt;
    logic [ChanCount-1:0] softPulse;
    logic [ChanCount-1:0] block;
    logic [ChanCount-1:0] enable;
    logic [ChanCount-1:0] altSel;
    logic [ChanCount-1:0] prio;
    logic [ChanCount-1:0] doneFlag;
    logic [ChanCount-1:0] doneIe;
    logic [ChanCount-1:0] sync1;
    logic [ChanCount-1:0] sync2;
    logic [ChanCount-1:0] sync3;
    logic [ChanCount-1:0] periph;
    logic [ChanCount-1:0] req;
    logic errFlag;
    logic errIe;
    logic irq;
  } dcr_state_type;

  dcr_state_type s_q;
  dcr_state_type s_d;
  logic doWrite;
  logic [ChanCount-1:0] wrBits;
  logic [31:0] strbMask;

  dcr_gate_if #(.ChanCount(ChanCount)) gif ();

  // Request gate fed from registered state
  assign gif.controllerOn = s_q.on;
  assign gif.chanOn = s_q.enable;
  assign gif.reqBlock = s_q.block;
  assign gif.softPulse = s_q.softPulse;
  assign gif.periphReq = s_q.periph;

  dcr_req_gate #(.ChanCount(ChanCount)) u_gate (
    .gif(gif)
  );

  // Write data lanes and the per-channel slice of held write data
  assign strbMask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}},
    {8{wstrb[0]}}};
  assign wrBits = s_q.wData[ChanCount-1:0];
  assign doWrite = s_q.awHeld & s_q.wHeld;

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    s_d.softPulse = '0;
    // Three-stage synchroniser, level taken when stages two and three agree
    s_d.sync1 = periphReqIn;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    s_d.periph = (s_q.sync2 & s_q.sync3) |
      (s_q.periph & (s_q.sync2 | s_q.sync3));
    // Address and data channels taken in either order
    if (awvalid && s_q.awReady) begin
      s_d.awHeld = 1'b1;
      s_d.awReady = 1'b0;
      s_d.awAddr = awaddr;
    end
    if (wvalid && s_q.wReady) begin
      s_d.wHeld = 1'b1;
      s_d.wReady = 1'b0;
      s_d.wData = wdata & strbMask;
      s_d.wMask = strbMask;
    end
    // Hardware clear of completed channels, before software writes
    s_d.enable = s_q.enable & ~chanDoneIn;
    if (doWrite) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = dcr_pkg::RESP_OKAY;
      case (s_q.awAddr)
        dcr_pkg::OFF_CFG: begin
          if (s_q.wMask[dcr_pkg::ON_BIT]) begin
            s_d.on = s_q.wData[dcr_pkg::ON_BIT];
          end
        end
        dcr_pkg::OFF_BASE: begin
          s_d.base = ((s_q.base & ~s_q.wMask) | s_q.wData) & ~RoMask;
        end
        dcr_pkg::OFF_ALT: begin
          s_d.bResp = dcr_pkg::RESP_OKAY;
        end
        dcr_pkg::OFF_SOFT: begin
          s_d.softPulse = wrBits;
        end
        dcr_pkg::OFF_BLKSET: begin
          s_d.block = s_q.block | wrBits;
        end
        dcr_pkg::OFF_BLKCLR: begin
          s_d.block = s_q.block & ~wrBits;
        end
        dcr_pkg::OFF_CHAN_ON_SET_BITS: begin
          s_d.enable = s_d.enable | wrBits;
        end
        dcr_pkg::OFF_CHAN_ON_CLEAR_BITS: begin
          s_d.enable = s_d.enable & ~wrBits;
        end
        dcr_pkg::OFF_ALTSET: begin
          s_d.altSel = s_q.altSel | wrBits;
        end
        dcr_pkg::OFF_ALTCLR: begin
          s_d.altSel = s_q.altSel & ~wrBits;
        end
        dcr_pkg::OFF_HIGH_PRIO_SET_BITS: begin
          s_d.prio = s_q.prio | wrBits;
        end
        dcr_pkg::OFF_HIGH_PRIO_CLEAR_BITS: begin
          s_d.prio = s_q.prio & ~wrBits;
        end
        dcr_pkg::OFF_ERRFLAG: begin
          s_d.errFlag = s_q.errFlag & ~s_q.wData[dcr_pkg::ERR_BIT];
        end
        dcr_pkg::OFF_DONEFLAG: begin
          s_d.doneFlag = s_q.doneFlag & ~wrBits;
        end
        dcr_pkg::OFF_DONEIESET: begin
          s_d.doneIe = s_q.doneIe | wrBits;
        end
        dcr_pkg::OFF_DONEIECLR: begin
          s_d.doneIe = s_q.doneIe & ~wrBits;
        end
        dcr_pkg::OFF_ERRIESET: begin
          s_d.errIe = s_q.errIe | s_q.wData[dcr_pkg::ERR_BIT];
        end
        dcr_pkg::OFF_ERRIECLR: begin
          s_d.errIe = s_q.errIe & ~s_q.wData[dcr_pkg::ERR_BIT];
        end
        default: begin
          s_d.bResp = dcr_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Hardware set wins over a same-cycle clear
    s_d.doneFlag = s_d.doneFlag | chanDoneIn;
    s_d.errFlag = s_d.errFlag | busErrorIn;
    if (s_q.bValid && bready) begin
      s_d.bValid = 1'b0;
      s_d.awReady = 1'b1;
      s_d.wReady = 1'b1;
    end
    // Read channel: data registered one edge after the address
    if (arvalid && s_q.arReady) begin
      s_d.arReady = 1'b0;
      s_d.rValid = 1'b1;
      s_d.rResp = dcr_pkg::RESP_OKAY;
      s_d.rData = 32'h0000_0000;
      case (araddr)
        dcr_pkg::OFF_CFG: s_d.rData = 32'h0000_0000;
        dcr_pkg::OFF_BASE: s_d.rData = s_q.base;
        dcr_pkg::OFF_ALT: s_d.rData = s_q.alt;
        dcr_pkg::OFF_SOFT: s_d.rData = 32'h0000_0000;
        dcr_pkg::OFF_BLKSET: s_d.rData = 32'(s_q.block);
        dcr_pkg::OFF_BLKCLR: s_d.rData = 32'h0000_0000;
        dcr_pkg::OFF_CHAN_ON_SET_BITS: s_d.rData = 32'(s_q.enable);
        dcr_pkg::OFF_CHAN_ON_CLEAR_BITS: s_d.rData = 32'h0000_0000;
        dcr_pkg::OFF_ALTSET: s_d.rData = 32'(s_q.altSel);
        dcr_pkg::OFF_ALTCLR: s_d.rData = 32'h0000_0000;
        dcr_pkg::OFF_HIGH_PRIO_SET_BITS: s_d.rData = 32'(s_q.prio);
        dcr_pkg::OFF_HIGH_PRIO_CLEAR_BITS: s_d.rData = 32'h0000_0000;
        dcr_pkg::OFF_ERRFLAG: s_d.rData = 32'(s_q.errFlag);
        dcr_pkg::OFF_DONEFLAG: s_d.rData = 32'(s_q.doneFlag);
        dcr_pkg::OFF_DONEIESET: s_d.rData = 32'(s_q.doneIe);
        dcr_pkg::OFF_DONEIECLR: s_d.rData = 32'h0000_0000;
        dcr_pkg::OFF_ERRIESET: s_d.rData = 32'(s_q.errIe);
        dcr_pkg::OFF_ERRIECLR: s_d.rData = 32'h0000_0000;
        default: s_d.rResp = dcr_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.rValid && rready) begin
      s_d.rValid = 1'b0;
      s_d.arReady = 1'b1;
    end
    // Derived alternate base, gated requests and interrupt
    s_d.alt = s_q.base | AltOffset;
    s_d.req = gif.chanReq;
    s_d.irq = (|(s_q.doneFlag & s_q.doneIe)) |
      (s_q.errFlag & s_q.errIe);
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.awReady <= 1'b1;
      s_q.wReady <= 1'b1;
      s_q.arReady <= 1'b1;
      s_q.base <= dcr_pkg::BASE_RESET;
      s_q.alt <= dcr_pkg::BASE_RESET | AltOffset;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign awready = s_q.awReady;
  assign wready = s_q.wReady;
  assign bvalid = s_q.bValid;
  assign bresp = s_q.bResp;
  assign arready = s_q.arReady;
  assign rvalid = s_q.rValid;
  assign rdata = s_q.rData;
  assign rresp = s_q.rResp;
  assign controllerOn = s_q.on;
  assign chanEnable = s_q.enable;
  assign altSelect = s_q.altSel;
  assign highPrio = s_q.prio;
  assign chanRequest = s_q.req;
  assign ctrlBaseAddr = s_q.base;
  assign altBaseAddr = s_q.alt;
  assign irq = s_q.irq;

  // Checks on register behaviour
  a_cfg_on_write: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && doWrite && s_q.awAddr == dcr_pkg::OFF_CFG && s_q.wMask[0]
    |=> controllerOn == $past(s_q.wData[0]))
    else $error("controller on bit not written");

  a_base_aligned: assert property (
    @(posedge core_clk) disable iff (reset)
    (ctrlBaseAddr & RoMask) == 32'h0000_0000)
    else $error("base pointer low bits not zero");

  a_alt_derived: assert property (@(posedge core_clk) disable iff (reset)
    clkEn ##1 $stable(ctrlBaseAddr)
    |-> altBaseAddr == (ctrlBaseAddr | AltOffset))
    else $error("alternate base mismatch");

  a_soft_request: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && doWrite && s_q.awAddr == dcr_pkg::OFF_SOFT && s_q.wData[0]
    && chanEnable[0] && controllerOn && !chanDoneIn[0] ##1 clkEn
    |=> chanRequest[0])
    else $error("soft request not forwarded");

  a_mask_set: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && doWrite && s_q.awAddr == dcr_pkg::OFF_BLKSET && s_q.wData[0]
    |=> s_q.block[0] ##1 (!clkEn || !chanRequest[0] || s_q.softPulse[0]
    || $past(s_q.softPulse[0])))
    else $error("mask set not effective");

  a_mask_clear: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && doWrite && s_q.awAddr == dcr_pkg::OFF_BLKCLR && s_q.wData[0]
    |=> !s_q.block[0])
    else $error("mask clear not effective");

  a_enable_set: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && doWrite && s_q.awAddr == dcr_pkg::OFF_CHAN_ON_SET_BITS && s_q.wData[0]
    |=> chanEnable[0])
    else $error("enable set not effective");

  a_done_disables: assert property (
    @(posedge core_clk) disable iff (reset)
    clkEn && chanDoneIn[0]
    && !(doWrite && s_q.awAddr == dcr_pkg::OFF_CHAN_ON_SET_BITS)
    |=> !chanEnable[0] && s_q.doneFlag[0])
    else $error("completion did not disable channel");

  a_error_set: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && busErrorIn |=> s_q.errFlag)
    else $error("bus error not flagged");

  a_irq_gated: assert property (@(posedge core_clk) disable iff (reset)
    clkEn |=> irq == ($past(|(s_q.doneFlag & s_q.doneIe))
    || ($past(s_q.errFlag) && $past(s_q.errIe))))
    else $error("interrupt not gated by enables");

endmodule // dma_channel_control_regs

// *** testbench/dcr_far_side.sv ***
// Model of the request sources and transfer engine beside the block
`timescale 1ns/1ps
module dcr_far_side #(
  parameter int ChanCount = 8
) (
  core_clk,
  periphReqIn,
  chanDoneIn,
  busErrorIn
);
  input wire logic core_clk;
  output logic [ChanCount-1:0] periphReqIn;
  output logic [ChanCount-1:0] chanDoneIn;
  output logic busErrorIn;

  // Idle sources at time zero
  initial begin
    periphReqIn = '0;
    chanDoneIn = '0;
    busErrorIn = 1'b0;
  end

  // Request levels move just after a clock edge
  task automatic set_req(input logic [ChanCount-1:0] v);
    @(posedge core_clk);
    periphReqIn <= v;
  endtask

  // One-cycle completion pulse for the channels in the mask
  task automatic fire_done(input logic [ChanCount-1:0] m);
    @(posedge core_clk);
    chanDoneIn <= m;
    @(posedge core_clk);
    chanDoneIn <= '0;
  endtask

  // One-cycle bus error pulse from the transfer master
  task automatic fire_error;
    @(posedge core_clk);
    busErrorIn <= 1'b1;
    @(posedge core_clk);
    busErrorIn <= 1'b0;
  endtask
endmodule // dcr_far_side

// *** testbench/dma_channel_control_regs_tb.sv ***
// Self-checking bench of the DMA channel control register block
`timescale 1ns/1ps
module dma_channel_control_regs_tb;
  localparam int N = 8;
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] re;
  } dcr_row_type;
  // Write one place, read one place, expected read value
  localparam dcr_row_type ROWS [16] = '{
    '{dcr_pkg::OFF_BASE, 32'hFFFFFFFF, dcr_pkg::OFF_BASE, 32'hFFFFFF00},
    '{dcr_pkg::OFF_BASE, 32'h12345678, dcr_pkg::OFF_ALT, 32'h12345680},
    '{dcr_pkg::OFF_ALT, 32'h0, dcr_pkg::OFF_ALT, 32'h12345680},
    '{dcr_pkg::OFF_BLKSET, 32'hFFFFFF05, dcr_pkg::OFF_BLKSET, 32'h5},
    '{dcr_pkg::OFF_BLKCLR, 32'h1, dcr_pkg::OFF_BLKSET, 32'h4},
    '{dcr_pkg::OFF_CHAN_ON_SET_BITS, 32'hF3, dcr_pkg::OFF_CHAN_ON_SET_BITS, 32'hF3},
    '{dcr_pkg::OFF_CHAN_ON_CLEAR_BITS, 32'h3, dcr_pkg::OFF_CHAN_ON_SET_BITS, 32'hF0},
    '{dcr_pkg::OFF_ALTSET, 32'h81, dcr_pkg::OFF_ALTSET, 32'h81},
    '{dcr_pkg::OFF_ALTCLR, 32'h80, dcr_pkg::OFF_ALTSET, 32'h1},
    '{dcr_pkg::OFF_HIGH_PRIO_SET_BITS, 32'h0F, dcr_pkg::OFF_HIGH_PRIO_SET_BITS, 32'h0F},
    '{dcr_pkg::OFF_HIGH_PRIO_CLEAR_BITS, 32'h0, dcr_pkg::OFF_HIGH_PRIO_SET_BITS, 32'h0F},
    '{dcr_pkg::OFF_DONEIESET, 32'h03, dcr_pkg::OFF_DONEIESET, 32'h3},
    '{dcr_pkg::OFF_DONEIECLR, 32'h01, dcr_pkg::OFF_DONEIESET, 32'h2},
    '{dcr_pkg::OFF_ERRIESET, 32'h1, dcr_pkg::OFF_ERRIESET, 32'h1},
    '{dcr_pkg::OFF_ERRIECLR, 32'h1, dcr_pkg::OFF_ERRIESET, 32'h0},
    '{dcr_pkg::OFF_HIGH_PRIO_CLEAR_BITS, 32'h5, dcr_pkg::OFF_HIGH_PRIO_SET_BITS, 32'h0A}};
  // Places read after reset and their reset values
  localparam logic [7:0] RST_A [7] = '{dcr_pkg::OFF_BASE, dcr_pkg::OFF_ALT,
    dcr_pkg::OFF_BLKSET, dcr_pkg::OFF_CHAN_ON_SET_BITS, dcr_pkg::OFF_ALTSET,
    dcr_pkg::OFF_HIGH_PRIO_SET_BITS, dcr_pkg::OFF_DONEFLAG};
  localparam logic [31:0] RST_E [7] = '{32'h0, 32'h80, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, controllerOn, irq;
  logic busErrorIn;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, ctrlBaseAddr, altBaseAddr, rd;
  logic [N-1:0] periphReqIn, chanDoneIn, chanEnable, altSelect, highPrio;
  logic [N-1:0] chanRequest;
  int error_cnt = 0;
  int n_compared = 0;
  int softCnt = 0;

  dma_channel_control_regs #(.ChanCount(N)) i_dut (.core_clk(core_clk),
    .reset(reset), .clkEn(clkEn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp),
    .periphReqIn(periphReqIn), .chanDoneIn(chanDoneIn),
    .busErrorIn(busErrorIn), .controllerOn(controllerOn),
    .chanEnable(chanEnable), .altSelect(altSelect), .highPrio(highPrio),
    .chanRequest(chanRequest), .ctrlBaseAddr(ctrlBaseAddr),
    .altBaseAddr(altBaseAddr), .irq(irq));

  dcr_far_side #(.ChanCount(N)) i_far (.core_clk(core_clk),
    .periphReqIn(periphReqIn), .chanDoneIn(chanDoneIn),
    .busErrorIn(busErrorIn));

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  // Counts cycles with a request on channel 2
  always @(posedge core_clk) begin
    if (chanRequest[2] === 1'b1) softCnt++;
  end

  // Word compare
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single output bit compare
  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // AXI4-Lite write, address and data offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 64);
    if (n >= 64) error_cnt++;
    resp = bresp;
    bready <= 1'b0;
  endtask

  // AXI4-Lite read
  task automatic axi_read(input logic [7:0] a);
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 64);
    if (n >= 64) error_cnt++;
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Write then read back and compare
  task automatic wr_rd(input logic [7:0] wa, input logic [31:0] wd,
    input logic [31:0] re);
    axi_write(wa, wd);
    axi_read(wa);
    check_word(rd, re);
  endtask

  // Counts, verdict and end of run
  task print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    print_verdict;
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    axi_write(dcr_pkg::OFF_CFG, 32'h1);
    foreach (ROWS[i]) begin
      axi_write(ROWS[i].wa, ROWS[i].wd);
      check_word({30'h0, resp}, {30'h0, dcr_pkg::RESP_OKAY});
      axi_read(ROWS[i].ra);
      check_word(rd, ROWS[i].re);
    end
    $display("test table done");
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    foreach (RST_A[i]) begin
      axi_read(RST_A[i]);
      check_word(rd, RST_E[i]);
    end
    axi_read(dcr_pkg::OFF_ERRFLAG);
    check_word(rd, 32'h0);
    check_bit(controllerOn, 1'b0);
    $display("test reset done");
    axi_write(dcr_pkg::OFF_CFG, 32'h1);
    wr_rd(dcr_pkg::OFF_CFG, 32'h1, 32'h0);
    check_bit(controllerOn, 1'b1);
    axi_write(dcr_pkg::OFF_CHAN_ON_SET_BITS, 32'h5);
    softCnt = 0;
    axi_write(dcr_pkg::OFF_SOFT, 32'h0);
    axi_write(dcr_pkg::OFF_SOFT, 32'hFFFFFF00);
    repeat (4) @(posedge core_clk);
    check_word(softCnt, 32'h0);
    axi_write(dcr_pkg::OFF_SOFT, 32'h5);
    repeat (4) @(posedge core_clk);
    check_word(softCnt, 32'h1);
    $display("test soft request done");
    axi_write(dcr_pkg::OFF_CHAN_ON_SET_BITS, 32'h2);
    axi_write(dcr_pkg::OFF_BLKSET, 32'h2);
    i_far.set_req(8'h02);
    repeat (8) @(posedge core_clk);
    check_bit(chanRequest[1], 1'b0);
    axi_write(dcr_pkg::OFF_BLKCLR, 32'h2);
    repeat (8) @(posedge core_clk);
    check_bit(chanRequest[1], 1'b1);
    axi_write(dcr_pkg::OFF_CFG, 32'h0);
    repeat (3) @(posedge core_clk);
    check_bit(chanRequest[1], 1'b0);
    i_far.set_req(8'h00);
    $display("test peripheral request done");
    axi_write(dcr_pkg::OFF_CHAN_ON_SET_BITS, 32'h10);
    i_far.fire_done(8'h11);
    axi_read(dcr_pkg::OFF_CHAN_ON_SET_BITS);
    check_word(rd, 32'h6);
    axi_read(dcr_pkg::OFF_DONEFLAG);
    check_word(rd, 32'h11);
    check_bit(irq, 1'b0);
    axi_write(dcr_pkg::OFF_DONEIESET, 32'h10);
    repeat (2) @(posedge core_clk);
    check_bit(irq, 1'b1);
    wr_rd(dcr_pkg::OFF_DONEFLAG, 32'h0, 32'h11);
    wr_rd(dcr_pkg::OFF_DONEFLAG, 32'h10, 32'h01);
    repeat (2) @(posedge core_clk);
    check_bit(irq, 1'b0);
    $display("test completion done");
    clkEn <= 1'b0;
    i_far.fire_error;
    @(posedge core_clk);
    clkEn <= 1'b1;
    axi_read(dcr_pkg::OFF_ERRFLAG);
    check_word(rd, 32'h0);
    $display("test clock enable done");
    i_far.fire_error;
    axi_read(dcr_pkg::OFF_ERRFLAG);
    check_word(rd, 32'h1);
    wr_rd(dcr_pkg::OFF_ERRFLAG, 32'h0, 32'h1);
    wr_rd(dcr_pkg::OFF_ERRFLAG, 32'h1, 32'h0);
    axi_write(dcr_pkg::OFF_ERRIESET, 32'h1);
    i_far.fire_error;
    repeat (2) @(posedge core_clk);
    check_bit(irq, 1'b1);
    axi_write(dcr_pkg::OFF_ERRIECLR, 32'h1);
    repeat (2) @(posedge core_clk);
    check_bit(irq, 1'b0);
    $display("test error flag done");
    axi_write(8'hF0, 32'hFFFFFFFF);
    check_word({30'h0, resp}, {30'h0, dcr_pkg::RESP_SLVERR});
    axi_read(8'hF0);
    check_word({30'h0, resp}, {30'h0, dcr_pkg::RESP_SLVERR});
    check_word(rd, 32'h0);
    $display("test unmapped done");
    print_verdict;
  end
endmodule // dma_channel_control_regs_tb
